// >>> logic/pfm_supervisor.sv
`timescale 1ns/1ps
module pfm_supervisor
  import pfm_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  input  wire logic       wake_pin_i,
  input  wire logic       rail_start_pin_i,
  input  wire pfm_fault_t fault_pins_i,
  input  wire logic [3:0] rail_in_reg_i,
  input  wire logic       rails_off_i,
  input  wire logic [8:0] nvm_default_i,
  input  wire logic       nvm_done_i,
  input  wire logic       adc_done_i,
  input  wire logic [9:0] adc_code_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [4:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic [7:0]      reg_rdata_o,
  output logic            rail_enable_o,
  output logic            fast_off_o,
  output logic            nvm_write_o,
  output logic [8:0]      nvm_code_o,
  output logic            adc_start_o,
  output logic            irq_out_n_o,
  output logic            irq_out_n_oe_n_o,
  output logic            rails_good_out_o,
  output logic            rails_good_out_oe_n_o
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  logic       wake_m, wake_s, start_m, start_s, start_q;
  pfm_fault_t flt_m, flt_s;
  logic [3:0] reg_m, reg_s;

  always_ff @(posedge clk_i)
    if (!rst_n_i)
    begin
      {wake_m, wake_s, start_m, start_s} <= 4'h0;
      {flt_m, flt_s} <= '0;
      {reg_m, reg_s} <= 8'h00;
    end
    else if (ce_i)
    begin
      {wake_m, wake_s, start_m, start_s} <= {wake_pin_i, wake_m, rail_start_pin_i, start_m};
      {flt_m, flt_s} <= {fault_pins_i, flt_m};
      {reg_m, reg_s} <= {rail_in_reg_i, reg_m};
    end

  // Wake low resets all registers except the synchronisers, start_q and the pin data
  wire lrst = !rst_n_i || !wake_s;

  // ****************************************
  // Registers and decode
  // ****************************************
  pfm_mode_t  mode, next_mode;
  logic [7:0] flg_a, flg_b, en_a, en_b, limits, temp;
  logic [8:0] bias;
  logic [1:0] dt;
  logic       commit_req, busy, base_ok, fast_q;
  logic signed [7:0] base;

  function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
    hit = (a == r);
  endfunction

  function automatic logic signed [7:0] lim_deg(input logic [3:0] l);
    lim_deg = $signed({4'h0, l} * LIM_STEP) + LIM_BASE;
  endfunction

  wire wr = reg_wr_i && wake_s;
  wire rd = reg_rd_i && wake_s;
  wire wr_en    = wr && hit(reg_addr_i, ADDR_ENABLE);
  wire up_req   = (wr_en && reg_wdata_i[EN_ACT]) || (start_s && !start_q);
  wire down_req = (wr_en && reg_wdata_i[EN_STBY]) || (!start_s && start_q);
  wire rd_fa    = rd && hit(reg_addr_i, ADDR_FLG_A);
  wire rd_fb    = rd && hit(reg_addr_i, ADDR_FLG_B);
  wire trig     = wr && hit(reg_addr_i, ADDR_TCFG) && reg_wdata_i[TC_TRIG];

  // ****************************************
  // Fault classes
  // ****************************************
  wire shut_flt = flt_s.thermal_shutdown_fault || flt_s.positive_boost_undervolt || flt_s.inverting_conv_undervolt || flt_s.input_undervolt_lockout;
  wire any_flt  = shut_flt || flt_s.bias_f || flt_s.pos_source_undervolt || flt_s.neg_source_undervolt
                  || flt_s.neg_gate_undervolt || flt_s.pos_gate_undervolt;
  wire blocked  = flg_a[FA_TSD] || flg_a[FA_BIAS] || flg_a[FA_INPUT_UNDERVOLT_LOCKOUT]
                  || flg_b[FB_VB] || flg_b[FB_VN];

  // ****************************************
  // Temperature conversion result
  // ****************************************
  wire signed [7:0] raw   = $signed({1'b0, adc_code_i[9:3]}) - TEMP_OFS;
  wire signed [7:0] t_new = (raw > TEMP_MAX) ? TEMP_MAX : raw;
  wire signed [8:0] diff  = {t_new[7], t_new} - {base[7], base};
  wire        [8:0] mag   = diff[8] ? 9'(-diff) : 9'(diff);
  wire        big   = base_ok && (mag >= {7'h00, dt} + 9'h001);
  wire        is_hot  = t_new >= lim_deg(limits[7:4]);
  wire        is_cold = t_new <= lim_deg(limits[3:0]);
  wire        eoc     = busy && adc_done_i;

  // Set terms; hardware set wins over a read clear
  wire [7:0] set_a = {1'b0, flt_s.input_undervolt_lockout, flt_s.bias_f, flt_s.thermal_shutdown_fault,
                      eoc && is_cold, eoc && is_hot, eoc && big,
                      mode == MD_COMMIT && nvm_done_i};
  wire [7:0] set_b = {1'b0, flt_s.neg_source_undervolt, flt_s.pos_source_undervolt, flt_s.neg_gate_undervolt,
                      flt_s.pos_gate_undervolt, flt_s.inverting_conv_undervolt, flt_s.positive_boost_undervolt, eoc};
  wire [7:0] nxt_a = (rd_fa ? 8'h00 : flg_a) | set_a;
  wire [7:0] nxt_b = (rd_fb ? 8'h00 : flg_b) | set_b;

  // ****************************************
  // Mode sequencing
  // ****************************************
  always_comb
  begin
    next_mode = mode;
    case (mode)
      MD_SLEEP:   next_mode = MD_STANDBY;
      MD_STANDBY:
        if (commit_req) next_mode = MD_COMMIT;
        else if (up_req && !blocked && !shut_flt) next_mode = MD_ACTIVE;
      MD_ACTIVE:
        if (shut_flt || flt_s.bias_f || down_req || commit_req)
          next_mode = MD_DOWN;
      MD_DOWN:
        if (rails_off_i) next_mode = commit_req ? MD_COMMIT : MD_STANDBY;
      MD_COMMIT:
        if (nvm_done_i) next_mode = MD_STANDBY;
      default:    next_mode = MD_SLEEP;
    endcase
  end

  wire pg_next  = (next_mode == MD_ACTIVE) && (&reg_s) && !any_flt;
  wire irq_next = |(nxt_a & en_a) || |(nxt_b & en_b);

  always_ff @(posedge clk_i)
    if (lrst)
    begin
      mode          <= MD_SLEEP;
      fast_q        <= 1'b0;
      rail_enable_o <= 1'b0;
      fast_off_o    <= 1'b0;
      nvm_write_o   <= 1'b0;
      irq_out_n_oe_n_o      <= 1'b1;
      rails_good_out_oe_n_o <= 1'b0;
    end
    else if (ce_i)
    begin
      mode          <= next_mode;
      fast_q        <= (next_mode == MD_DOWN) && (fast_q || flt_s.bias_f);
      rail_enable_o <= next_mode == MD_ACTIVE;
      fast_off_o    <= (next_mode == MD_DOWN) && (fast_q || flt_s.bias_f);
      nvm_write_o   <= (next_mode == MD_COMMIT) && !nvm_done_i;
      irq_out_n_oe_n_o      <= !irq_next;
      rails_good_out_oe_n_o <= pg_next;
    end

  // Open-drain pins only ever drive low
  always_ff @(posedge clk_i)
    if (!rst_n_i)
    begin
      irq_out_n_o      <= 1'b0;
      rails_good_out_o <= 1'b0;
      start_q          <= 1'b0;
    end
    else if (ce_i)
    begin
      irq_out_n_o      <= 1'b0;
      rails_good_out_o <= 1'b0;
      start_q          <= wake_s && start_s;
    end

  // ****************************************
  // Register file and temperature monitor
  // ****************************************
  // Bias code reloads from its stored default on every wake
  always_ff @(posedge clk_i)
    if (lrst)
    begin
      flg_a <= 8'h00;
      flg_b <= 8'h00;
      en_a  <= RST_EN_A;
      en_b  <= RST_EN_B;
      dt    <= RST_DT;
      limits <= RST_LIMITS;
      bias  <= nvm_default_i;
      commit_req <= 1'b0;
      busy  <= 1'b0;
      adc_start_o <= 1'b0;
      temp  <= 8'h00;
      base  <= 8'sh00;
      base_ok <= 1'b0;
    end
    else if (ce_i)
    begin
      flg_a <= nxt_a;
      flg_b <= nxt_b;
      if (wr && hit(reg_addr_i, ADDR_EN_A)) en_a <= reg_wdata_i;
      if (wr && hit(reg_addr_i, ADDR_EN_B)) en_b <= reg_wdata_i;
      if (wr && hit(reg_addr_i, ADDR_TCFG)) dt <= reg_wdata_i[1:0];
      if (wr && hit(reg_addr_i, ADDR_LIMITS)) limits <= reg_wdata_i;
      if (wr && hit(reg_addr_i, ADDR_BIAS_L)) bias[7:0] <= reg_wdata_i;
      if (wr && hit(reg_addr_i, ADDR_BIAS_H))
        bias[8] <= reg_wdata_i[0];
      if (mode == MD_COMMIT && nvm_done_i) commit_req <= 1'b0;
      else if (wr && hit(reg_addr_i, ADDR_BIAS_H) && reg_wdata_i[BH_NVM_COMMIT_REQUEST])
        commit_req <= 1'b1;
      adc_start_o <= trig && !busy;
      busy <= eoc ? 1'b0 : (busy || trig);
      if (eoc)
      begin
        temp <= t_new;
        if (!base_ok || big) base <= t_new;
        base_ok <= 1'b1;
      end
    end

  assign nvm_code_o = bias;

  wire [7:0] rdata_next =
      hit(reg_addr_i, ADDR_TEMP)   ? temp :
      hit(reg_addr_i, ADDR_ENABLE) ? {rail_enable_o, mode == MD_STANDBY, 6'h00} :
      hit(reg_addr_i, ADDR_BIAS_L) ? bias[7:0] :
      hit(reg_addr_i, ADDR_BIAS_H) ? {1'b0, commit_req, 5'h00, bias[8]} :
      hit(reg_addr_i, ADDR_EN_A)   ? en_a :
      hit(reg_addr_i, ADDR_EN_B)   ? en_b :
      hit(reg_addr_i, ADDR_FLG_A)  ? flg_a :
      hit(reg_addr_i, ADDR_FLG_B)  ? flg_b :
      hit(reg_addr_i, ADDR_TCFG)   ? {2'h0, !busy, 3'h0, dt} :
      hit(reg_addr_i, ADDR_LIMITS) ? limits :
      hit(reg_addr_i, ADDR_PGOOD)  ? {4'h0, reg_s} : 8'h00;

  always_ff @(posedge clk_i)
    if (lrst)
      reg_rdata_o <= 8'h00;
    else if (ce_i && rd)
      reg_rdata_o <= rdata_next;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (lrst || !ce_i);

  logic [11:0] held;
  always_ff @(posedge clk_i)
    // A masked cause may legally keep the pin released
    if (lrst || !flt_s.pos_source_undervolt || !en_b[FB_VPOS] || !ce_i)
      held <= 12'h000;
    else if (irq_out_n_oe_n_o && held != 12'hFFF)
      held <= held + 12'h001;

  sequence s_commit_go;
    mode == MD_DOWN && rails_off_i && commit_req;
  endsequence
  sequence s_commit_end;
    mode == MD_COMMIT && nvm_done_i;
  endsequence

  a_commit_order: assert property (nvm_write_o |-> !rail_enable_o)
    else $error("nvm write while rails on");
  a_commit_enter: assert property (s_commit_go |=> nvm_write_o)
    else $error("commit did not start after rails off");
  a_commit_flag: assert property (s_commit_end |=> flg_a[FA_DONE] ##1 !irq_out_n_oe_n_o
                                  or !en_a[FA_DONE])
    else $error("commit done flag missing");
  a_fault_down: assert property (mode == MD_ACTIVE && shut_flt |=> mode == MD_DOWN)
    else $error("main fault did not start shutdown");
  a_bias_fast: assert property (mode == MD_ACTIVE && flt_s.bias_f |=> fast_off_o)
    else $error("bias fault not immediate");
  a_fault_pins: assert property (any_flt |=> !rails_good_out_oe_n_o && (|flg_a || |flg_b))
    else $error("fault did not pull good low");
  a_no_restart: assert property (mode == MD_STANDBY && blocked |=> mode != MD_ACTIVE)
    else $error("rails restarted with flags set");
  a_src_uv_stay: assert property (mode == MD_ACTIVE && !shut_flt && !flt_s.bias_f
                                  && !down_req && !commit_req |=> mode == MD_ACTIVE)
    else $error("source undervolt left active");
  a_good_cause: assert property (rails_good_out_oe_n_o |-> rail_enable_o && $past(&reg_s))
    else $error("good released without regulation");
  a_irq_level: assert property ((|(flg_a & en_a) || |(flg_b & en_b)) |-> ##1 !irq_out_n_oe_n_o
                                or ##1 $past(rd_fa || rd_fb))
    else $error("irq not pulled low");
  a_irq_again: assert property (held < 12'(REASSERT_CYC))
    else $error("persisting cause not re-flagged");
  a_temp_clamp: assert property (eoc |=> $signed(temp) <= TEMP_MAX
                                 && $signed(temp) >= TEMP_MIN)
    else $error("temperature out of clamp");
  a_conv_start: assert property (trig && !busy |=> busy && adc_start_o)
    else $error("trigger did not start conversion");
  a_temp_flags: assert property (eoc && is_hot |=> flg_a[FA_HOT] && flg_b[FB_EOC])
    else $error("hot and end flags not together");
  a_cold_flag: assert property (eoc && is_cold |=> flg_a[FA_COLD])
    else $error("cold flag missing");
endmodule // pfm_supervisor

// >>> logic/pfm_pkg.sv
package pfm_pkg;
  // Register indices as printed on the serial register map
  localparam logic [4:0] ADDR_TEMP   = 5'h00;
  localparam logic [4:0] ADDR_ENABLE = 5'h01;
  localparam logic [4:0] ADDR_BIAS_L = 5'h03;
  localparam logic [4:0] ADDR_BIAS_H = 5'h04;
  localparam logic [4:0] ADDR_EN_A   = 5'h05;
  localparam logic [4:0] ADDR_EN_B   = 5'h06;
  localparam logic [4:0] ADDR_FLG_A  = 5'h07;
  localparam logic [4:0] ADDR_FLG_B  = 5'h08;
  localparam logic [4:0] ADDR_TCFG   = 5'h0D;
  localparam logic [4:0] ADDR_LIMITS = 5'h0E;
  localparam logic [4:0] ADDR_PGOOD  = 5'h0F;
  // Flag group A bit positions
  localparam int FA_DONE = 0;
  localparam int FA_DTX  = 1;
  localparam int FA_HOT  = 2;
  localparam int FA_COLD = 3;
  localparam int FA_TSD  = 4;
  localparam int FA_BIAS = 5;
  localparam int FA_INPUT_UNDERVOLT_LOCKOUT = 6;
  // Flag group B bit positions
  localparam int FB_EOC  = 0;
  localparam int FB_VB   = 1;
  localparam int FB_VN   = 2;
  localparam int FB_VDDH = 3;
  localparam int FB_VEE  = 4;
  localparam int FB_VPOS = 5;
  localparam int FB_VNEG = 6;
  // Control bit positions
  localparam int EN_ACT   = 7;
  localparam int EN_STBY  = 6;
  localparam int BH_NVM_COMMIT_REQUEST  = 6;
  localparam int TC_TRIG  = 7;
  localparam int TC_IDLE  = 5;
  // Reset values
  localparam logic [7:0] RST_EN_A   = 8'h7D;
  localparam logic [7:0] RST_EN_B   = 8'h7F;
  localparam logic [1:0] RST_DT     = 2'h1;
  localparam logic [7:0] RST_LIMITS = 8'hC1;
  // Temperature scaling
  localparam logic signed [7:0] TEMP_OFS  = 8'sh0A;
  localparam logic signed [7:0] TEMP_MAX  = 8'sh55;
  localparam logic signed [7:0] TEMP_MIN  = 8'shF6;
  localparam logic signed [7:0] LIM_BASE  = 8'shF6;
  localparam logic [7:0]        LIM_STEP  = 8'h06;
  // Re-assertion bound for a persisting cause
  localparam int REASSERT_NS  = 32000;
  localparam int CLK_NS       = 25;
  localparam int REASSERT_CYC = REASSERT_NS / CLK_NS;

  typedef struct packed {
    logic thermal_shutdown_fault;
    logic positive_boost_undervolt;
    logic inverting_conv_undervolt;
    logic input_undervolt_lockout;
    logic bias_f;
    logic pos_source_undervolt;
    logic neg_source_undervolt;
    logic neg_gate_undervolt;
    logic pos_gate_undervolt;
  } pfm_fault_t;

  typedef enum logic [2:0] {
    MD_SLEEP, MD_STANDBY, MD_ACTIVE, MD_DOWN, MD_COMMIT
  } pfm_mode_t;
endpackage

// >>> testbench/pfm_far_side.sv
`timescale 1ns/1ps
module pfm_far_side
  import pfm_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rail_enable_i,
  input  wire logic       fast_off_i,
  input  wire logic       nvm_write_i,
  input  wire logic [8:0] nvm_code_i,
  input  wire logic       adc_start_i,
  input  wire logic [9:0] conv_value_i,
  input  wire logic [7:0] delay_i,
  output logic            rails_off_o,
  output logic [8:0]      nvm_default_o,
  output logic            nvm_done_o,
  output logic            adc_done_o,
  output logic [9:0]      adc_code_o
);
  int         down_cnt = 0;
  int         conv_cnt = -1;
  int         nvm_cnt  = 0;
  logic [9:0] held     = 10'h000;
  initial
  begin
    rails_off_o   = 1'b1;
    nvm_default_o = 9'h000;
    nvm_done_o    = 1'b0;
    adc_done_o    = 1'b0;
    adc_code_o    = 10'h3FF;
  end
  // Slow discharge unless switched off at once
  always @(posedge clk_i)
  begin
    if (rail_enable_i)
      down_cnt <= delay_i;
    else if (fast_off_i)
      down_cnt <= 0;
    else if (down_cnt > 0)
      down_cnt <= down_cnt - 1;
    rails_off_o <= !rail_enable_i && (fast_off_i || down_cnt == 0);
  end
  // Commit stores the code as next default
  always @(posedge clk_i)
  begin
    nvm_cnt    <= nvm_write_i ? nvm_cnt + 1 : 0;
    nvm_done_o <= nvm_write_i && nvm_cnt >= delay_i;
    if (nvm_write_i && nvm_cnt == delay_i)
      nvm_default_o <= nvm_code_i;
  end
  // Code line only valid with the done pulse; scrambled otherwise
  always @(posedge clk_i)
  begin
    adc_done_o <= 1'b0;
    adc_code_o <= ~adc_code_o;
    if (adc_start_i)
    begin
      conv_cnt <= delay_i;
      held     <= conv_value_i;
    end
    else if (conv_cnt == 0)
    begin
      adc_done_o <= 1'b1;
      adc_code_o <= held;
      conv_cnt   <= -1;
    end
    else if (conv_cnt > 0)
      conv_cnt <= conv_cnt - 1;
  end
endmodule // pfm_far_side

// >>> testbench/pmic_fault_irq_temp_monitor_tb.sv
`timescale 1ns/1ps
module pmic_fault_irq_temp_monitor_tb;
  import pfm_pkg::*;
  logic       clk_i, rst_n_i, wake, start, reg_wr, reg_rd, rails_off, nvm_done, adc_done;
  logic       rail_en, fast_off, nvm_wr, adc_start, irq_n, irq_oe_n, good_n, good_oe_n;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, rdata, pdelay, d;
  logic [3:0] in_reg;
  logic [8:0] nvm_def, nvm_code, code9;
  logic [9:0] adc_code, conv_value;
  pfm_fault_t flt;
  int         fails, checks, base, first;
  pfm_supervisor u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .wake_pin_i(wake),
    .rail_start_pin_i(start), .fault_pins_i(flt), .rail_in_reg_i(in_reg),
    .rails_off_i(rails_off), .nvm_default_i(nvm_def), .nvm_done_i(nvm_done),
    .adc_done_i(adc_done), .adc_code_i(adc_code), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(rdata),
    .rail_enable_o(rail_en), .fast_off_o(fast_off), .nvm_write_o(nvm_wr),
    .nvm_code_o(nvm_code), .adc_start_o(adc_start), .irq_out_n_o(irq_n),
    .irq_out_n_oe_n_o(irq_oe_n), .rails_good_out_o(good_n),
    .rails_good_out_oe_n_o(good_oe_n));
  pfm_far_side u_far (.clk_i(clk_i), .rail_enable_i(rail_en), .fast_off_i(fast_off),
    .nvm_write_i(nvm_wr), .nvm_code_i(nvm_code), .adc_start_i(adc_start),
    .conv_value_i(conv_value), .delay_i(pdelay), .rails_off_o(rails_off),
    .nvm_default_o(nvm_def), .nvm_done_o(nvm_done), .adc_done_o(adc_done),
    .adc_code_o(adc_code));
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // ************************************************************
  // Bus cycles and comparisons
  // ************************************************************
  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [8:0] s, input logic [8:0] e);
    checks++;
    if (s !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(negedge clk_i);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, v};
    @(negedge clk_i);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    @(negedge clk_i);
    {reg_rd, reg_addr} = {1'b1, a};
    @(negedge clk_i);
    reg_rd = 1'b0;
    v = rdata;
  endtask
  task automatic wsig(ref logic s, input logic v, input int n);
    for (int k = 0; k < n && s !== v; k++)
      @(negedge clk_i);
    chk("wait", s, v);
    if (s !== v)
      conclude();
  endtask
  task automatic poll(input logic [4:0] a, input logic [7:0] m, input logic [7:0] v);
    rd(a, d);
    for (int k = 0; k < 300 && (d & m) !== v; k++)
      rd(a, d);
    chk("poll", d & m, v);
    if ((d & m) !== v)
      conclude();
  endtask
  task automatic conv(input int code, input logic [7:0] lim, input logic [1:0] dt,
                      input logic [7:0] ea, input logic [7:0] eb);
    int  t, hf, cf, dti;
    logic hot, cold, temp_change_flag;
    {hf, cf, dti} = {32'(lim[7:4]), 32'(lim[3:0]), 32'(dt)};
    wr(ADDR_LIMITS, lim);
    wr(ADDR_EN_A, ea);
    wr(ADDR_EN_B, eb);
    conv_value = code[9:0];
    wr(ADDR_TCFG, {1'b1, 5'h00, dt});
    chk("start pulse", adc_start, 1'b1);
    rd(ADDR_TCFG, d);
    chk("busy", d[TC_IDLE], 1'b0);
    poll(ADDR_TCFG, 8'h20, 8'h20);
    t = (code >> 3) - 10;
    t = (t > 85) ? 85 : t;
    hot = t >= -10 + 6 * hf;
    cold = t <= -10 + 6 * cf;
    temp_change_flag = !first && (t - base > dti || base - t > dti);
    base = (first || temp_change_flag) ? t : base;
    first = 0;
    chk("irq", irq_oe_n, !((hot && ea[FA_HOT]) || (cold && ea[FA_COLD]) ||
        (temp_change_flag && ea[FA_DTX]) || eb[FB_EOC]));
    rd(ADDR_TEMP, d);
    chk("temp", d, t[7:0]);
    rd(ADDR_FLG_A, d);
    chk("flags a", d, {4'h0, cold, hot, temp_change_flag, 1'b0});
    rd(ADDR_FLG_B, d);
    chk("flags b", d, 8'h01);
  endtask
  // ************************************************************
  // Main sequence
  // ************************************************************
  logic [4:0] raddr[5] = '{ADDR_EN_A, ADDR_EN_B, ADDR_LIMITS, ADDR_TCFG, 5'h1F};
  logic [7:0] rmask[5] = '{8'hFF, 8'hFF, 8'hFF, 8'h23, 8'hFF};
  logic [7:0] rval[5]  = '{8'h7D, 8'h7F, 8'hC1, 8'h21, 8'h00};
  initial
  begin
    {rst_n_i, wake, start, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {flt, in_reg, conv_value, pdelay} = '0;
    {fails, checks, base, first} = {32'd0, 32'd0, 32'd0, 32'd1};
    wake = 1'b1;
    void'($urandom(92));
    repeat (10) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk("irq idle", irq_oe_n, 1'b1);
    chk("pin data", {irq_n, good_n}, 2'b00);
    chk("good idle", good_oe_n, 1'b0);
    foreach (raddr[i])
    begin
      rd(raddr[i], d);
      chk("reset value", d & rmask[i], rval[i]);
    end
    pdelay = 8'd40;
    conv(160, 8'hF0, 2'h1, 8'h7D, 8'h00);
    conv(600, 8'hF0, 2'h1, 8'h7D, 8'h00);
    conv(1023, 8'hF0, 2'h1, 8'h7F, 8'h00);
    for (int i = 0; i < 12; i++)
    begin
      pdelay = (i % 2) ? 8'd2 : 8'd40;
      conv($urandom_range(0, 1023), 8'($urandom), 2'($urandom), 8'($urandom), 8'($urandom));
    end
    wr(ADDR_EN_A, 8'h7D);
    wr(ADDR_EN_B, 8'h7F);
    in_reg = 4'hF;
    wr(ADDR_ENABLE, 8'h80);
    poll(ADDR_ENABLE, 8'h80, 8'h80);
    wsig(good_oe_n, 1'b1, 20);
    in_reg = 4'h7;
    wsig(good_oe_n, 1'b0, 20);
    in_reg = 4'hF;
    flt.pos_source_undervolt = 1'b1;
    wsig(irq_oe_n, 1'b0, 20);
    chk("good on uv", good_oe_n, 1'b0);
    rd(ADDR_FLG_B, d);
    rd(ADDR_FLG_B, d);
    chk("uv flag held", d[FB_VPOS], 1'b1);
    chk("still up", rail_en, 1'b1);
    flt.pos_source_undervolt = 1'b0;
    repeat (4) @(negedge clk_i);
    rd(ADDR_FLG_B, d);
    wsig(irq_oe_n, 1'b1, 20);
    wsig(good_oe_n, 1'b1, 20);
    wr(ADDR_ENABLE, 8'h40);
    wsig(good_oe_n, 1'b0, 20);
    poll(ADDR_ENABLE, 8'hC0, 8'h40);
    wr(ADDR_ENABLE, 8'h80);
    poll(ADDR_ENABLE, 8'h80, 8'h80);
    chk("pin data", {irq_n, good_n}, 2'b00);
    flt.thermal_shutdown_fault = 1'b1;
    wsig(rail_en, 1'b0, 20);
    chk("ordered off", fast_off, 1'b0);
    poll(ADDR_ENABLE, 8'hC0, 8'h40);
    rd(ADDR_FLG_A, d);
    chk("tsd flag", d, 8'h10);
    wsig(irq_oe_n, 1'b0, REASSERT_CYC);
    flt.thermal_shutdown_fault = 1'b0;
    start = 1'b1;
    repeat (6) @(negedge clk_i);
    chk("blocked", rail_en, 1'b0);
    start = 1'b0;
    rd(ADDR_FLG_A, d);
    rd(ADDR_FLG_B, d);
    repeat (6) @(negedge clk_i);
    start = 1'b1;
    wsig(rail_en, 1'b1, 20);
    flt.bias_f = 1'b1;
    wsig(fast_off, 1'b1, 20);
    flt.bias_f = 1'b0;
    poll(ADDR_ENABLE, 8'hC0, 8'h40);
    rd(ADDR_FLG_A, d);
    chk("bias flag", d, 8'h20);
    rd(ADDR_FLG_B, d);
    wr(ADDR_EN_A, 8'h00);
    flt.input_undervolt_lockout = 1'b1;
    repeat (8) @(negedge clk_i);
    chk("masked", irq_oe_n, 1'b1);
    rd(ADDR_FLG_A, d);
    chk("flag kept", d, 8'h40);
    flt.input_undervolt_lockout = 1'b0;
    repeat (4) @(negedge clk_i);
    rd(ADDR_FLG_A, d);
    wr(ADDR_EN_A, 8'h7D);
    start = 1'b0;
    repeat (6) @(negedge clk_i);
    start = 1'b1;
    poll(ADDR_ENABLE, 8'h80, 8'h80);
    code9 = 9'($urandom);
    wr(ADDR_BIAS_L, code9[7:0]);
    wr(ADDR_BIAS_H, {1'b0, 1'b1, 5'h00, code9[8]});
    wsig(nvm_wr, 1'b1, 300);
    chk("rails off first", {rails_off, rail_en}, 2'b10);
    chk("commit code", nvm_code, code9);
    wsig(irq_oe_n, 1'b0, 300);
    rd(ADDR_FLG_A, d);
    chk("done flag", d, 8'h01);
    wr(ADDR_BIAS_L, 8'h00);
    wr(ADDR_BIAS_H, 8'h00);
    wake = 1'b0;
    repeat (6) @(negedge clk_i);
    rd(ADDR_EN_B, d);
    chk("asleep", d, 8'h00);
    wake = 1'b1;
    first = 1;
    repeat (4) @(negedge clk_i);
    rd(ADDR_BIAS_L, d);
    chk("default lo", d, code9[7:0]);
    rd(ADDR_BIAS_H, d);
    chk("default hi", d[0], code9[8]);
    conv(400, 8'hF0, 2'h3, 8'h7F, 8'h01);
    conclude();
  end
  initial
  begin
    repeat (90000) @(negedge clk_i);
    fails++;
    conclude();
  end
endmodule // pmic_fault_irq_temp_monitor_tb
